// >>> hdl/tro_map.vh
// Register offsets, field positions, reset values and timing counts of the readout block.
`ifndef TRO_MAP_VH
`define TRO_MAP_VH
`define TRO_ADDR_CLK_CFG 8'h89
`define TRO_ADDR_TRIG 8'hA4
`define TRO_ADDR_FMT 8'hCB
`define TRO_ADDR_OPT 8'hCC
`define TRO_CLK_CFG_RST 8'h01
`define TRO_TRIG_RST 8'h00
`define TRO_FMT_RST 8'h00
`define TRO_OPT_RST 8'h40
`define TRO_CLK_SEL_LSB 0
`define TRO_CLK_SEL_MSB 1
`define TRO_CLK_POL_BIT 7
`define TRO_TRIG_SW_BIT 0
`define TRO_TRIG_CONT_BIT 1
`define TRO_TRIG_BUSY_BIT 2
`define TRO_FMT_MODE_LSB 0
`define TRO_FMT_MODE_MSB 1
`define TRO_FMT_SATINS_BIT 6
`define TRO_OPT_SATPIN_BIT 6
`define TRO_MODE_12 2'h0
`define TRO_MODE_MSB_LSB 2'h1
`define TRO_MODE_LSB_MSB 2'h2
`define TRO_MODE_8 2'h3
`define TRO_REF_MHZ 200
`define TRO_OSC_MHZ 4
`define TRO_OSC_DIV (`TRO_REF_MHZ / `TRO_OSC_MHZ)
`define TRO_STRAP_OSC_PERIODS 4
`define TRO_STRAP_CYC (`TRO_STRAP_OSC_PERIODS * `TRO_OSC_DIV)
`define TRO_EE_COPY_US 340
`define TRO_EE_COPY_CYC (`TRO_EE_COPY_US * `TRO_REF_MHZ)
`define TRO_EE_CLK_CFG_ADDR 7'h00
`define TRO_EE_FMT_ADDR 7'h01
`define TRO_EE_OPT_ADDR 7'h02
`define TRO_OUTPUT_PIXEL_CLOCK_12_STEP 9'h018
`define TRO_OUTPUT_PIXEL_CLOCK_24_STEP 9'h030
`define TRO_OUTPUT_PIXEL_CLOCK_48_STEP 9'h060
`define TRO_OUTPUT_PIXEL_CLOCK_ACC_WRAP 9'h0C8
`endif

// >>> hdl/tro_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module tro_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire full_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign full_o = (count_reg == DEPTH[AW:0]);
  assign in_ready_o = ~full_o;
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // tro_fifo
`default_nettype wire

// >>> hdl/tro_readout.v
// Readout output port, capture trigger, strap scan and start-up copy of the imager.
//
// Contract
// - Strap pins become pulled-down inputs four osc periods.
// - Row-valid strap sets A1, frame-valid strap A0.
// - Start-up copy loads config registers within limit.
// - Output clock selectable 12, 24, 48 MHz.
// - Output clock toggles continuously, blanking included.
// - Outputs change on active output clock edge.
// - Frame valid, then row valid, successive edges.
// - Frame valid spans frame; row valid spans pair.
// - Saturation pin, or frame end when option cleared.
// - Pair is top row then bottom row, ascending.
// - Twelve-bit two's-complement pixel plus saturation bit.
// - A started frame completes without pause.
// - Cycle sends mode-defined frame count back to back.
// - Conversion of two rows, column-independent duration.
// - Row pair takes 26.7 us at 24 MHz.
// - Cycle starts on trigger pin or software bit.
// - Software trigger bit clears itself when taken.
// - Next frame acquired right after previous readout.
// - Format register selects one of four word modes.
// - Continuous bit or late pin restarts cycle; earlier ignored.
`include "tro_map.vh"
`default_nettype none
module tro_readout #(
  parameter COLS = 320,
  parameter PAIRS = 120,
  parameter GAP_CLKS = 8,
  parameter EE_COPY_CYC = `TRO_EE_COPY_CYC
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_we_i,
  input wire reg_re_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg [6:0] ee_addr_o,
  input wire [7:0] ee_data_i,
  output wire boot_done_o,
  input wire pix_valid_i,
  output wire pix_ready_o,
  input wire [11:0] pix_data_i,
  input wire pix_sat_i,
  input wire [3:0] frames_per_cycle_i,
  input wire capture_trigger_i,
  output wire output_pixel_clock_o,
  output reg [11:1] camera_parallel_output_o,
  input wire data0_i,
  output wire data0_o,
  output wire data0_oe_n_o,
  input wire frame_valid_addr0_i,
  output wire frame_valid_addr0_o,
  output wire frame_valid_addr0_oe_n_o,
  input wire row_pair_valid_addr1_i,
  output wire row_pair_valid_addr1_o,
  output wire row_pair_valid_addr1_oe_n_o,
  input wire saturation_or_frame_end_i,
  output wire saturation_or_frame_end_o,
  output wire saturation_or_frame_end_oe_n_o,
  output wire strap_pulldown_o,
  output reg [1:0] slave_addr_low_o,
  output reg [1:0] reserved_strap_o,
  output reg underrun_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_FSTART = 3'h1;
  localparam ST_GAP = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_FEND = 3'h4;
  localparam [7:0] STRAP_LAST = `TRO_STRAP_CYC - 1;
  localparam [16:0] COPY_LEN = EE_COPY_CYC;

  // Builds one output word from a pixel for the selected transfer mode and byte phase.
  function [11:0] fmt_word;
    input [11:0] pix;
    input saturation_flag;
    input [1:0] mode;
    input second;
    input sat_ins;
    reg [7:0] msb;
    begin
      msb = {saturation_flag & sat_ins, 3'h0, pix[11:8]};
      case (mode)
        `TRO_MODE_MSB_LSB: fmt_word = {4'h0, second ? pix[7:0] : msb};
        `TRO_MODE_LSB_MSB: fmt_word = {4'h0, second ? msb : pix[7:0]};
        `TRO_MODE_8: fmt_word = {4'h0, pix[11:4]};
        default: fmt_word = pix;
      endcase
    end
  endfunction

  reg [7:0] clk_cfg_reg;
  reg [7:0] trig_reg;
  reg [7:0] fmt_reg;
  reg [7:0] opt_reg;
  reg [16:0] boot_cnt_reg;
  reg [7:0] strap_cnt_reg;
  reg scan_reg;
  reg [3:0] strap_s1_reg;
  reg [3:0] strap_s2_reg;
  reg trig_s1_reg;
  reg trig_s2_reg;
  reg trig_s3_reg;
  reg hw_pend_reg;
  reg [8:0] acc_reg;
  reg output_pixel_clock_reg;
  reg [2:0] st_reg;
  reg fv_reg;
  reg rv_reg;
  reg sat_pin_reg;
  reg [11:0] d_reg;
  reg [3:0] frame_cnt_reg;
  reg [7:0] pair_cnt_reg;
  reg [9:0] word_cnt_reg;
  reg second_reg;
  reg [12:0] hold_reg;
  reg [7:0] gap_cnt_reg;
  reg late_trig_reg;
  reg pop_reg;

  wire copying = (boot_cnt_reg < COPY_LEN);
  wire [8:0] acc_step = (clk_cfg_reg[`TRO_CLK_SEL_MSB:`TRO_CLK_SEL_LSB] == 2'h0) ? `TRO_OUTPUT_PIXEL_CLOCK_12_STEP :
                        (clk_cfg_reg[`TRO_CLK_SEL_MSB:`TRO_CLK_SEL_LSB] == 2'h2) ? `TRO_OUTPUT_PIXEL_CLOCK_48_STEP :
                        `TRO_OUTPUT_PIXEL_CLOCK_24_STEP;
  wire [8:0] acc_sum = acc_reg + acc_step;
  wire tog = (acc_sum >= `TRO_OUTPUT_PIXEL_CLOCK_ACC_WRAP);
  wire act = tog & ~output_pixel_clock_reg;
  wire split = (fmt_reg[1:0] == `TRO_MODE_MSB_LSB) | (fmt_reg[1:0] == `TRO_MODE_LSB_MSB);
  wire sat_mode = opt_reg[`TRO_OPT_SATPIN_BIT];
  wire start_req = trig_reg[`TRO_TRIG_SW_BIT] | hw_pend_reg;
  wire last_pair = (pair_cnt_reg == PAIRS[7:0] - 8'h01);
  wire last_frame = (frame_cnt_reg + 4'h1 >= frames_per_cycle_i);
  wire last_word = (word_cnt_reg == COLS[9:0] * 10'h002 - 10'h001) & (~split | ~second_reg);
  wire fifo_valid;
  wire fifo_full;
  wire [12:0] fifo_data;
  wire [12:0] cur = (split & second_reg) ? hold_reg : fifo_data;
  // A set second_reg means the trailing byte of hold_reg is still owed to the port.
  wire [11:0] first_word = fmt_word(fifo_data[11:0], fifo_data[12], fmt_reg[1:0], 1'b0, fmt_reg[`TRO_FMT_SATINS_BIT]);
  wire [11:0] next_word = fmt_word(cur[11:0], cur[12], fmt_reg[1:0], split & second_reg, fmt_reg[`TRO_FMT_SATINS_BIT]);

  tro_fifo #(
    .WIDTH(13),
    .DEPTH(16),
    .AW(4)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .in_data_i({pix_sat_i, pix_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop_reg),
    .out_data_o(fifo_data),
    .full_o(fifo_full)
  );

  // Strap scan: pins float with pull-downs while the scan window runs.
  assign strap_pulldown_o = scan_reg;
  assign frame_valid_addr0_oe_n_o = scan_reg;
  assign row_pair_valid_addr1_oe_n_o = scan_reg;
  assign saturation_or_frame_end_oe_n_o = scan_reg;
  assign data0_oe_n_o = scan_reg;
  assign frame_valid_addr0_o = fv_reg;
  assign row_pair_valid_addr1_o = rv_reg;
  assign saturation_or_frame_end_o = sat_pin_reg;
  assign data0_o = d_reg[0];
  assign output_pixel_clock_o = output_pixel_clock_reg ^ clk_cfg_reg[`TRO_CLK_POL_BIT];
  assign boot_done_o = ~copying & ~scan_reg;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_s1_reg <= 4'h0;
      strap_s2_reg <= 4'h0;
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else begin
      strap_s1_reg <= {saturation_or_frame_end_i, data0_i, row_pair_valid_addr1_i, frame_valid_addr0_i};
      strap_s2_reg <= strap_s1_reg;
      trig_s1_reg <= capture_trigger_i;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scan_reg <= 1'b1;
      strap_cnt_reg <= 8'h00;
      slave_addr_low_o <= 2'h0;
      reserved_strap_o <= 2'h0;
    end else if (scan_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 8'h01;
      if (strap_cnt_reg == STRAP_LAST) begin
        scan_reg <= 1'b0;
        slave_addr_low_o <= {strap_s2_reg[1], strap_s2_reg[0]};
        reserved_strap_o <= {strap_s2_reg[3], strap_s2_reg[2]};
      end
    end
  end

  // Start-up copy reads three bytes in the first cycles, then waits out the copy window.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_cnt_reg <= 17'h00000;
      ee_addr_o <= `TRO_EE_CLK_CFG_ADDR;
      clk_cfg_reg <= `TRO_CLK_CFG_RST;
      fmt_reg <= `TRO_FMT_RST;
      opt_reg <= `TRO_OPT_RST;
    end else begin
      if (copying) begin
        boot_cnt_reg <= boot_cnt_reg + 17'h00001;
      end
      ee_addr_o <= (boot_cnt_reg == 17'h00000) ? `TRO_EE_FMT_ADDR : `TRO_EE_OPT_ADDR;
      if (copying) begin
        case (boot_cnt_reg)
          17'h00001: clk_cfg_reg <= ee_data_i;
          17'h00002: fmt_reg <= ee_data_i;
          17'h00003: opt_reg <= ee_data_i;
          default: clk_cfg_reg <= clk_cfg_reg;
        endcase
      end else if (reg_we_i) begin
        case (reg_addr_i)
          `TRO_ADDR_CLK_CFG: clk_cfg_reg <= reg_wdata_i;
          `TRO_ADDR_FMT: fmt_reg <= reg_wdata_i;
          `TRO_ADDR_OPT: opt_reg <= reg_wdata_i;
          default: fmt_reg <= fmt_reg;
        endcase
      end
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `TRO_ADDR_CLK_CFG: reg_rdata_o <= clk_cfg_reg;
        `TRO_ADDR_TRIG: reg_rdata_o <= {5'h00, st_reg != ST_IDLE, trig_reg[1:0]};
        `TRO_ADDR_FMT: reg_rdata_o <= fmt_reg;
        `TRO_ADDR_OPT: reg_rdata_o <= opt_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Output clock runs from release of reset regardless of frame activity.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_reg <= 9'h000;
      output_pixel_clock_reg <= 1'b0;
    end else begin
      acc_reg <= tog ? acc_sum - `TRO_OUTPUT_PIXEL_CLOCK_ACC_WRAP : acc_sum;
      if (tog) begin
        output_pixel_clock_reg <= ~output_pixel_clock_reg;
      end
    end
  end

  // Trigger capture; a pin edge outside idle is dropped, except during the last pair of the last frame.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_reg <= `TRO_TRIG_RST;
      hw_pend_reg <= 1'b0;
    end else begin
      if (trig_s2_reg & ~trig_s3_reg & st_reg == ST_IDLE & boot_done_o) begin
        hw_pend_reg <= 1'b1;
      end else if (act & st_reg == ST_IDLE & start_req) begin
        hw_pend_reg <= 1'b0;
      end
      if (reg_we_i & reg_addr_i == `TRO_ADDR_TRIG & ~copying) begin
        trig_reg <= {6'h00, reg_wdata_i[1:0]};
      end else if (act & st_reg == ST_IDLE & start_req & boot_done_o) begin
        trig_reg[`TRO_TRIG_SW_BIT] <= 1'b0;
      end
    end
  end

  // Frame sequencer; every output update happens on an active output clock edge.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= ST_IDLE;
      fv_reg <= 1'b0;
      rv_reg <= 1'b0;
      sat_pin_reg <= 1'b0;
      d_reg <= 12'h000;
      camera_parallel_output_o <= 11'h000;
      frame_cnt_reg <= 4'h0;
      pair_cnt_reg <= 8'h00;
      word_cnt_reg <= 10'h000;
      second_reg <= 1'b0;
      hold_reg <= 13'h0000;
      gap_cnt_reg <= 8'h00;
      late_trig_reg <= 1'b0;
      pop_reg <= 1'b0;
      underrun_o <= 1'b0;
    end else begin
      pop_reg <= 1'b0;
      if (fv_reg & last_frame & last_pair & trig_s2_reg) begin
        late_trig_reg <= 1'b1;
      end
      if (act) begin
        case (st_reg)
          ST_IDLE: begin
            sat_pin_reg <= 1'b0;
            frame_cnt_reg <= 4'h0;
            if (start_req & boot_done_o & frames_per_cycle_i != 4'h0) begin
              st_reg <= ST_FSTART;
            end
          end
          ST_FSTART: begin
            sat_pin_reg <= 1'b0;
            pair_cnt_reg <= 8'h00;
            late_trig_reg <= 1'b0;
            if (fifo_full) begin
              fv_reg <= 1'b1;
              gap_cnt_reg <= 8'h00;
              st_reg <= ST_GAP;
            end
          end
          ST_GAP: begin
            if (gap_cnt_reg != 8'hFF) begin
              gap_cnt_reg <= gap_cnt_reg + 8'h01;
            end
            // The conversion gap is at least GAP_CLKS output clocks, skipped before the first pair, and does not depend on the column count.
            if ((gap_cnt_reg >= GAP_CLKS[7:0] | pair_cnt_reg == 8'h00) & fifo_full) begin
              rv_reg <= 1'b1;
              word_cnt_reg <= 10'h000;
              second_reg <= split;
              hold_reg <= fifo_data;
              pop_reg <= 1'b1;
              d_reg <= first_word;
              camera_parallel_output_o <= first_word[11:1];
              sat_pin_reg <= sat_mode & fifo_data[12];
              st_reg <= ST_DATA;
            end
          end
          ST_DATA: begin
            // A row pair runs to its end; a starved stream repeats words and flags underrun.
            if (last_word) begin
              rv_reg <= 1'b0;
              sat_pin_reg <= 1'b0;
              gap_cnt_reg <= 8'h00;
              pair_cnt_reg <= pair_cnt_reg + 8'h01;
              st_reg <= last_pair ? ST_FEND : ST_GAP;
            end else begin
              if (~(split & second_reg)) begin
                word_cnt_reg <= word_cnt_reg + 10'h001;
              end
              second_reg <= split & ~second_reg;
              if (~(split & second_reg)) begin
                hold_reg <= fifo_data;
                pop_reg <= fifo_valid;
                underrun_o <= underrun_o | ~fifo_valid;
              end
              d_reg <= next_word;
              camera_parallel_output_o <= next_word[11:1];
              sat_pin_reg <= sat_mode & cur[12];
            end
          end
          ST_FEND: begin
            fv_reg <= 1'b0;
            sat_pin_reg <= ~sat_mode;
            frame_cnt_reg <= frame_cnt_reg + 4'h1;
            if (~last_frame) begin
              st_reg <= ST_FSTART;
            end else if (trig_reg[`TRO_TRIG_CONT_BIT] | late_trig_reg) begin
              frame_cnt_reg <= 4'h0;
              st_reg <= ST_FSTART;
            end else begin
              st_reg <= ST_IDLE;
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // tro_readout
`default_nettype wire

// >>> verif/tro_readout_sva.sv
// Port-level assertions for the readout block.
`default_nettype none
module tro_readout_sva #(
  parameter int EE_COPY_CYC = 40
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic boot_done_o,
  input wire logic strap_pulldown_o,
  input wire logic [1:0] slave_addr_low_o,
  input wire logic output_pixel_clock_o,
  input wire logic [11:1] camera_parallel_output_o,
  input wire logic frame_valid_addr0_o,
  input wire logic frame_valid_addr0_oe_n_o,
  input wire logic row_pair_valid_addr1_o,
  input wire logic row_pair_valid_addr1_oe_n_o,
  input wire logic saturation_or_frame_end_oe_n_o,
  input wire logic data0_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] age_reg;
  logic [3:0] still_reg;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      age_reg <= 20'h00000;
      still_reg <= 4'h0;
    end else begin
      age_reg <= age_reg + {19'h00000, age_reg != 20'hFFFFF};
      still_reg <= $stable(output_pixel_clock_o) ? still_reg + {3'h0, still_reg != 4'hF} : 4'h0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_scan_hold: assert property (age_reg < 20'd199 |-> strap_pulldown_o)
    else $error("Strap scan ended early.");
  a_scan_end: assert property (age_reg > 20'd201 |-> !strap_pulldown_o)
    else $error("Strap scan overran.");
  a_pins_released: assert property (strap_pulldown_o |-> frame_valid_addr0_oe_n_o &&
    row_pair_valid_addr1_oe_n_o && saturation_or_frame_end_oe_n_o && data0_oe_n_o)
    else $error("Strap pin driven during scan.");
  a_addr_latched: assert property (!strap_pulldown_o && !$past(strap_pulldown_o) |->
    $stable(slave_addr_low_o)) else $error("Address bits changed after scan.");
  a_boot_bound: assert property (age_reg > EE_COPY_CYC + 210 |-> boot_done_o)
    else $error("Start-up copy too long.");
  a_rv_in_frame: assert property (row_pair_valid_addr1_o |-> frame_valid_addr0_o)
    else $error("Row valid outside frame.");
  a_fv_before_rv: assert property ($rose(frame_valid_addr0_o) |-> !row_pair_valid_addr1_o ##1
    !row_pair_valid_addr1_o) else $error("Row valid with frame valid.");
  a_sync_on_edge: assert property ($changed(frame_valid_addr0_o) || $changed(row_pair_valid_addr1_o) ||
    $changed(camera_parallel_output_o) |-> $changed(output_pixel_clock_o)) else $error("Output off clock edge.");
  a_clk_running: assert property (boot_done_o && $past(boot_done_o, 16) |-> still_reg < 4'd9)
    else $error("Output clock stalled.");
  c_frame: cover property ($rose(frame_valid_addr0_o));
  c_row: cover property ($rose(row_pair_valid_addr1_o));
  c_frame_end: cover property ($fell(frame_valid_addr0_o));
endmodule // tro_readout_sva
bind tro_readout tro_readout_sva #(.EE_COPY_CYC(EE_COPY_CYC)) u_sva (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .boot_done_o(boot_done_o),
  .strap_pulldown_o(strap_pulldown_o), .slave_addr_low_o(slave_addr_low_o),
  .output_pixel_clock_o(output_pixel_clock_o), .camera_parallel_output_o(camera_parallel_output_o),
  .frame_valid_addr0_o(frame_valid_addr0_o), .frame_valid_addr0_oe_n_o(frame_valid_addr0_oe_n_o),
  .row_pair_valid_addr1_o(row_pair_valid_addr1_o), .row_pair_valid_addr1_oe_n_o(row_pair_valid_addr1_oe_n_o),
  .saturation_or_frame_end_oe_n_o(saturation_or_frame_end_oe_n_o), .data0_oe_n_o(data0_oe_n_o));
`default_nettype wire

// >>> verif/tro_rx_model.sv
// Receiver model standing on the far side of the parallel output port.
`default_nettype none
module tro_rx_model (
  input wire logic pclk_i,
  input wire logic pol_i,
  input wire logic fv_i,
  input wire logic rv_i,
  input wire logic sat_i,
  input wire logic [11:0] data_i,
  input wire logic chk_en_i,
  input wire logic fend_mode_i,
  output int word_cnt_o,
  output int frame_cnt_o,
  output int fend_cnt_o,
  output int err_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fv_q = 1'b0;
  logic sat_q = 1'b0;
  logic have_q = 1'b0;
  logic [11:0] prev_q = 12'h000;
  initial begin
    word_cnt_o = 0;
    frame_cnt_o = 0;
    fend_cnt_o = 0;
    err_cnt_o = 0;
  end
  // Samples on the non-active edge, in the middle of each data interval.
  always @(pclk_i) begin
    if (pclk_i === pol_i) begin
      if (rv_i === 1'b1) begin
        word_cnt_o++;
        if (chk_en_i && have_q && data_i !== prev_q + 12'h001) err_cnt_o++;
        if (chk_en_i && !fend_mode_i && sat_i !== data_i[3]) err_cnt_o++;
        prev_q = data_i;
        have_q = chk_en_i;
      end
      if (fv_i !== 1'b1) have_q = 1'b0;
      if (fv_q && fv_i === 1'b0) frame_cnt_o++;
      if (fend_mode_i && fv_i === 1'b0 && sat_i === 1'b1 && !sat_q) fend_cnt_o++;
      fv_q = (fv_i === 1'b1);
      sat_q = (sat_i === 1'b1);
    end
  end
endmodule // tro_rx_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the readout block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_we_i = 1'b0, reg_re_i = 1'b0, trig = 1'b0, pol = 1'b0, chk = 1'b0, fend = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, ee_data_i = 8'h00, r;
  logic [11:0] pix_data_i = 12'h7F0;
  wire [7:0] reg_rdata_o;
  wire [6:0] ee_addr_o;
  wire [11:1] dout;
  wire [1:0] addr_low, rsv;
  wire boot, rdy, pclk, d0_o, d0_oe_n, fv_o, fv_oe_n, rv_o, rv_oe_n, sat_o, sat_oe_n, pull, unr;
  int error_cnt = 0, tests_run = 0, word_cnt, frame_cnt, fend_cnt, rx_err, w0, f0, e0, k;
  // Pull-up on the A0 strap only; reserved straps left without pull-ups.
  wire fv_pin = fv_oe_n ? 1'b1 : fv_o;
  wire rv_pin = rv_oe_n ? 1'b0 : rv_o;
  wire sat_pin = sat_oe_n ? 1'b0 : sat_o;
  wire d0_pin = d0_oe_n ? 1'b0 : d0_o;
  logic [7:0] row_clk [4] = '{8'h00, 8'h01, 8'h02, 8'h82};
  logic [7:0] row_fmt [4] = '{8'h00, 8'h03, 8'h01, 8'h42};
  int row_words [4] = '{32, 32, 64, 64};
  always #2.5 ref_clk_i = ~ref_clk_i;
  // The start-up memory answers one cycle after its address, as the copy expects.
  logic [6:0] ee_prev = 7'h00;
  always @(negedge ref_clk_i) begin
    ee_data_i <= (ee_prev == 7'h02) ? 8'h40 : 8'h00;
    ee_prev <= ee_addr_o;
  end
  always @(negedge ref_clk_i) if (rdy) pix_data_i <= pix_data_i + 12'h001;
  tro_readout #(.COLS(4), .PAIRS(2), .EE_COPY_CYC(40)) uut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ee_addr_o(ee_addr_o),
    .ee_data_i(ee_data_i), .boot_done_o(boot), .pix_valid_i(1'b1), .pix_ready_o(rdy),
    .pix_data_i(pix_data_i), .pix_sat_i(pix_data_i[3]), .frames_per_cycle_i(4'h2),
    .capture_trigger_i(trig), .output_pixel_clock_o(pclk), .camera_parallel_output_o(dout),
    .data0_i(d0_pin), .data0_o(d0_o), .data0_oe_n_o(d0_oe_n), .frame_valid_addr0_i(fv_pin),
    .frame_valid_addr0_o(fv_o), .frame_valid_addr0_oe_n_o(fv_oe_n), .row_pair_valid_addr1_i(rv_pin),
    .row_pair_valid_addr1_o(rv_o), .row_pair_valid_addr1_oe_n_o(rv_oe_n), .saturation_or_frame_end_i(sat_pin),
    .saturation_or_frame_end_o(sat_o), .saturation_or_frame_end_oe_n_o(sat_oe_n), .strap_pulldown_o(pull),
    .slave_addr_low_o(addr_low), .reserved_strap_o(rsv), .underrun_o(unr));
  tro_rx_model u_rx (.pclk_i(pclk), .pol_i(pol), .fv_i(fv_pin), .rv_i(rv_pin), .sat_i(sat_pin),
    .data_i({dout, d0_pin}), .chk_en_i(chk), .fend_mode_i(fend), .word_cnt_o(word_cnt),
    .frame_cnt_o(frame_cnt), .fend_cnt_o(fend_cnt), .err_cnt_o(rx_err));
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1'b1;
    @(negedge ref_clk_i);
    reg_we_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_re_i = 1'b1;
    @(negedge ref_clk_i);
    reg_re_i = 1'b0;
    r = reg_rdata_o;
  endtask
  task automatic wait_frames(input int n);
    for (k = 0; frame_cnt < n && k < 30000; k++) @(negedge ref_clk_i);
    check(frame_cnt >= n, "frames missing");
  endtask
  task automatic idle();
    r = 8'h04;
    for (k = 0; r[2] !== 1'b0 && k < 3000; k++) rd(8'hA4);
    check(r[2] === 1'b0, "cycle never ended");
  endtask
  // Reset with the clock already running; a write inside the copy window is dropped.
  task automatic do_reset();
    reset_n_i = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    wr(8'h89, 8'h02);
    for (k = 0; boot !== 1'b1 && k < 1000; k++) @(negedge ref_clk_i);
    rd(8'h89);
    check(r === 8'h00, "copied clock config wrong");
    rd(8'hCC);
    check(r === 8'h40, "copied option register wrong");
    rd(8'h00);
    check(r === 8'h00, "unmapped read not zero");
    check(addr_low === 2'b01, "address straps wrong");
    check(rsv === 2'b00, "reserved straps wrong");
    $display("Test reset done");
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    $display("Error at %0t ns: watchdog expired", $time);
    conclude();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) begin
      wr(8'h89, row_clk[i]);
      wr(8'hCB, row_fmt[i]);
      pol = row_clk[i][7];
      chk = (row_fmt[i] == 8'h00);
      w0 = word_cnt;
      f0 = frame_cnt;
      wr(8'hA4, 8'h01);
      wait_frames(f0 + 2);
      idle();
      check(word_cnt - w0 == row_words[i], "word count wrong");
      rd(8'hA4);
      check(r[0] === 1'b0, "software trigger stuck");
      $display("Test row %0d done", i);
    end
    wr(8'h89, 8'h01);
    wr(8'hCB, 8'h00);
    pol = 1'b0;
    chk = 1'b1;
    wr(8'hCC, 8'h00);
    fend = 1'b1;
    f0 = frame_cnt;
    e0 = fend_cnt;
    trig = 1'b1;
    repeat (50) @(negedge ref_clk_i);
    trig = 1'b0;
    for (k = 0; fv_pin !== 1'b1 && k < 5000; k++) @(negedge ref_clk_i);
    check(fv_pin === 1'b1, "pin trigger ignored");
    trig = 1'b1;
    repeat (50) @(negedge ref_clk_i);
    trig = 1'b0;
    wait_frames(f0 + 2);
    idle();
    // Leave room for a wrongly accepted early trigger to show a frame.
    repeat (600) @(negedge ref_clk_i);
    check(frame_cnt == f0 + 2, "early trigger started a cycle");
    check(fend_cnt - e0 == 2, "frame end pulses wrong");
    wr(8'hCC, 8'h40);
    fend = 1'b0;
    $display("Test pin trigger done");
    f0 = frame_cnt;
    wr(8'hA4, 8'h03);
    wait_frames(f0 + 4);
    wr(8'hA4, 8'h00);
    idle();
    check(rx_err == 0, "received stream wrong");
    check(unr === 1'b0, "stream underran");
    $display("Test continuous done");
    do_reset();
    conclude();
  end
endmodule // testbench
`default_nettype wire
